// file: hdl/rtcbd_top.sv
// backup-domain real-time clock with apb registers and backup words
`timescale 1ns/1ps
module rtcbd_top
  import rtcbd_pkg::*;
#(
  parameter int NBKP = RTCBD_NBKP
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        bkp_rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        lse_clk_in,
  input  wire logic        lsi_clk_in,
  input  wire logic        fast_external_clock_in,
  output logic             cal_out,
  output logic             alarm_irq,
  output logic             second_irq,
  output logic             alarm_event,
  output logic             standby_wake
);

  typedef struct packed {
    logic [2:0]            lse_s;
    logic [2:0]            lsi_s;
    logic [2:0]            fex_s;
    logic [6:0]            fex_div;
    rtcbd_src_t            sel;
    logic                  cal_en;
    logic                  aie;
    logic                  sie;
    logic [19:0]           presc;
    logic [19:0]           div;
    logic [31:0]           cnt;
    logic [31:0]           alarm;
    logic                  sec_f;
    logic                  alr_f;
    logic                  alr_pulse;
    logic [4:0]            cal_div;
    logic                  cal_q;
    logic [NBKP-1:0][15:0] bkp;
  } rtcbd_core_t;

  typedef struct packed {
    logic [31:0] rdata;
    logic        err;
  } rtcbd_bus_t;

  rtcbd_core_t c;
  rtcbd_core_t next_c;
  rtcbd_bus_t  b;
  rtcbd_bus_t  next_b;

  logic       rtc_tick;
  logic       sec_tick;
  logic       fex_tick;
  logic       wr;
  logic       cnt_wr;
  logic       bkp_hit;
  logic       bkp_wr;
  logic [7:0] bkp_ofs;
  logic [7:0] bkp_idx;
  logic       reg_hit;

  localparam logic [7:0] BKP_END = 8'(RTCBD_BKP_OFS + 8'(4 * NBKP));

  // backup window decode
  always_comb begin
    bkp_ofs = paddr - RTCBD_BKP_OFS;
    bkp_idx = {2'b00, bkp_ofs[7:2]};
    bkp_hit = (paddr >= RTCBD_BKP_OFS) && (paddr < BKP_END) && (paddr[1:0] == 2'b00);
    reg_hit = (paddr == RTCBD_CTRL_OFS) || (paddr == RTCBD_STAT_OFS) ||
              (paddr == RTCBD_PRESC_OFS) || (paddr == RTCBD_DIV_OFS) ||
              (paddr == RTCBD_CNT_OFS) || (paddr == RTCBD_ALARM_OFS);
    wr      = psel && penable && pwrite;
    cnt_wr  = wr && (paddr == RTCBD_CNT_OFS);
    bkp_wr  = wr && bkp_hit;
  end

  // core: only the backup-domain reset clears it, never presetn
  always_comb begin
    next_c = c;
    // pins pass two flops; the third keeps history for edge detection
    next_c.lse_s = {c.lse_s[1:0], lse_clk_in};
    next_c.lsi_s = {c.lsi_s[1:0], lsi_clk_in};
    next_c.fex_s = {c.fex_s[1:0], fast_external_clock_in};
    fex_tick = 1'b0;
    // fast clock counted in pclk; it must stay well under half of pclk
    if (c.fex_s[1] && !c.fex_s[2]) begin
      next_c.fex_div = c.fex_div + 7'h01;
      fex_tick       = (c.fex_div == 7'(RTCBD_FAST_DIV - 1));
    end
    unique case (c.sel)
      RTCBD_SRC_LSE:  rtc_tick = c.lse_s[1] && !c.lse_s[2];
      RTCBD_SRC_LSI:  rtc_tick = c.lsi_s[1] && !c.lsi_s[2];
      RTCBD_SRC_FAST: rtc_tick = fex_tick;
      RTCBD_SRC_OFF:  rtc_tick = 1'b0;
    endcase
    // no low-power input gates the tick, so it runs on in stop and standby
    sec_tick = 1'b0;
    if (rtc_tick) begin
      if (c.div == 20'h00000) begin
        next_c.div = c.presc;
        sec_tick   = 1'b1;
      end else begin
        next_c.div = c.div - 20'h00001;
      end
      next_c.cal_div = c.cal_div + 5'h01;
      if (c.cal_div == 5'(RTCBD_CAL_HALF - 1)) begin
        next_c.cal_q = !c.cal_q;
      end
    end
    if (sec_tick && !cnt_wr) begin
      next_c.cnt = c.cnt + 32'h00000001;
    end
    next_c.alr_pulse = 1'b0;
    // software side; status bits clear on writing one
    if (wr) begin
      unique case (paddr)
        RTCBD_CTRL_OFS: begin
          next_c.sel    = rtcbd_src_t'(pwdata[RTCBD_SEL_LSB +: 2]);
          next_c.cal_en = pwdata[RTCBD_CAL_BIT];
          next_c.aie    = pwdata[RTCBD_AIE_BIT];
          next_c.sie    = pwdata[RTCBD_SIE_BIT];
        end
        RTCBD_STAT_OFS: begin
          if (pwdata[RTCBD_SEC_BIT]) begin
            next_c.sec_f = 1'b0;
          end
          if (pwdata[RTCBD_ALR_BIT]) begin
            next_c.alr_f = 1'b0;
          end
        end
        RTCBD_PRESC_OFS: next_c.presc = pwdata[19:0];
        RTCBD_CNT_OFS:   next_c.cnt   = pwdata;
        RTCBD_ALARM_OFS: next_c.alarm = pwdata;
        default: begin
          if (bkp_hit) begin
            next_c.bkp[bkp_idx] = pwdata[15:0];
          end
        end
      endcase
    end
    // hardware sets come last so they win over a clear in the same cycle
    if (sec_tick) begin
      next_c.sec_f = 1'b1;
      if (!cnt_wr && (c.cnt + 32'h00000001 == c.alarm) && !c.alr_f) begin
        next_c.alr_f     = 1'b1;
        next_c.alr_pulse = 1'b1;
      end else if (!cnt_wr && (c.cnt + 32'h00000001 == c.alarm)) begin
        next_c.alr_f = 1'b1;
      end
    end
  end

  // backup words and clock state survive presetn and standby wake-up
  always_ff @(posedge pclk or negedge bkp_rst_n) begin
    if (!bkp_rst_n) begin
      c         <= '0;
      c.sel     <= RTCBD_SRC_LSE;
      c.presc   <= RTCBD_PRESC_RST;
      c.div     <= RTCBD_PRESC_RST;
      c.cnt     <= RTCBD_CNT_RST;
      c.alarm   <= RTCBD_ALARM_RST;
    end else begin
      c <= next_c;
    end
  end

  // read data is fetched in the setup cycle, so pready never waits
  always_comb begin
    next_b = b;
    if (psel && !penable) begin
      next_b.rdata = 32'h00000000;
      next_b.err   = !(reg_hit || bkp_hit);
      unique case (paddr)
        RTCBD_CTRL_OFS: begin
          next_b.rdata[RTCBD_SEL_LSB +: 2] = c.sel;
          next_b.rdata[RTCBD_CAL_BIT]      = c.cal_en;
          next_b.rdata[RTCBD_AIE_BIT]      = c.aie;
          next_b.rdata[RTCBD_SIE_BIT]      = c.sie;
        end
        RTCBD_STAT_OFS: begin
          next_b.rdata[RTCBD_SEC_BIT] = c.sec_f;
          next_b.rdata[RTCBD_ALR_BIT] = c.alr_f;
        end
        RTCBD_PRESC_OFS: next_b.rdata[19:0] = c.presc;
        RTCBD_DIV_OFS:   next_b.rdata[19:0] = c.div;
        RTCBD_CNT_OFS:   next_b.rdata       = c.cnt;
        RTCBD_ALARM_OFS: next_b.rdata       = c.alarm;
        default: begin
          if (bkp_hit) begin
            next_b.rdata[15:0] = c.bkp[bkp_idx];
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      b <= '0;
    end else begin
      b <= next_b;
    end
  end

  assign prdata       = b.rdata;
  assign pslverr      = b.err && psel && penable;
  assign pready       = 1'b1;
  assign cal_out      = c.cal_q && c.cal_en;
  assign alarm_irq    = c.alr_f && c.aie;
  assign second_irq   = c.sec_f && c.sie;
  assign alarm_event  = c.alr_pulse;
  assign standby_wake = c.alr_f;

  default clocking dc @(posedge pclk); endclocking
  default disable iff (!bkp_rst_n);

  sequence alr_rise_s;
    !c.alr_f ##1 c.alr_f;
  endsequence

  sequence pulse_once_s;
    alarm_event ##1 !alarm_event;
  endsequence

  cnt_step_a: assert property (sec_tick && !cnt_wr |=> c.cnt == $past(c.cnt) + 1)
    else $error("counter did not step by one on tick");

  presc_reload_a: assert property (sec_tick |=> c.div == $past(c.presc))
    else $error("prescaler did not reload after tick");

  tick_only_zero_a: assert property (rtc_tick && c.div != 0 |=> c.div == $past(c.div) - 1)
    else $error("prescaler did not count down");

  alarm_cause_a: assert property ($rose(c.alr_f) |-> $past(sec_tick) && $past(c.cnt) + 1 == $past(c.alarm))
    else $error("alarm flag rose without a match");

  period_flag_a: assert property (sec_tick |=> c.sec_f ##0 (second_irq == c.sie))
    else $error("periodic flag missing after tick");

  fast_div_a: assert property (c.sel == RTCBD_SRC_FAST && rtc_tick |=> c.fex_div == 7'h00)
    else $error("fast clock divider out of step");

  cal_toggle_a: assert property ($changed(c.cal_q) |-> $past(rtc_tick) && $past(c.cal_div) == 5'h1f)
    else $error("calibration output toggled off schedule");

  bkp_write_a: assert property (bkp_wr |=> c.bkp[$past(bkp_idx)] == $past(pwdata[15:0]))
    else $error("backup word did not take the write");

  bkp_keep_a: assert property (@(posedge pclk) disable iff (!bkp_rst_n) !bkp_wr |=> $stable(c.bkp))
    else $error("backup words changed without a write");

  wake_pulse_a: assert property (alr_rise_s |-> pulse_once_s and standby_wake)
    else $error("alarm event line not pulsed once");

  // further checks on counter, sources and the bus side
  // read data is taken at the setup edge, so access-phase checks look one edge back
  // presetn may clear the read flops at any time, hence the escape in the hold check
  sequence alarm_hit_s;
    sec_tick && !cnt_wr && (c.cnt + 32'h00000001 == c.alarm);
  endsequence

  sequence bkp_rd_setup_s;
    psel && !penable && !pwrite && bkp_hit;
  endsequence

  sequence access_s;
    psel && penable;
  endsequence

  sequence flag_clear_s;
    wr && (paddr == RTCBD_STAT_OFS) && pwdata[RTCBD_SEC_BIT];
  endsequence

  sequence fex_edge_s;
    c.fex_s[1] && !c.fex_s[2];
  endsequence

  alarm_set_a: assert property (alarm_hit_s |=> c.alr_f && standby_wake)
    else $error("alarm flag not set on a match");

  event_gap_a: assert property (alarm_event |=> !alarm_event)
    else $error("alarm event line held longer than one cycle");

  cnt_hold_a: assert property (!sec_tick && !cnt_wr |=> $stable(c.cnt))
    else $error("counter moved without a tick");

  cnt_load_a: assert property (cnt_wr |=> c.cnt == $past(pwdata))
    else $error("counter did not take the write");

  src_off_a: assert property (c.sel == RTCBD_SRC_OFF |-> !rtc_tick)
    else $error("tick seen with the source switched off");

  fex_count_a: assert property (fex_edge_s |=> c.fex_div == 7'($past(c.fex_div) + 7'h01))
    else $error("fast clock divider missed an edge");

  div_ro_a: assert property (wr && (paddr == RTCBD_DIV_OFS) && !rtc_tick |=> $stable(c.div))
    else $error("remaining count changed by a write");

  presc_keep_a: assert property (!(wr && (paddr == RTCBD_PRESC_OFS)) |=> $stable(c.presc))
    else $error("prescaler reload changed without a write");

  set_wins_a: assert property (flag_clear_s ##0 sec_tick |=> c.sec_f)
    else $error("periodic flag lost to a same-cycle clear");

  bkp_read_a: assert property (bkp_rd_setup_s |=> prdata == {16'h0000, $past(c.bkp[bkp_idx])})
    else $error("backup word read back wrong");

  rd_hold_a: assert property (access_s |=> $stable(prdata) || !presetn)
    else $error("read data moved during the access phase");

  err_hole_a: assert property (access_s ##0 !(reg_hit || bkp_hit) |-> pslverr && (prdata == 32'h00000000))
    else $error("unmapped access not refused");

  err_none_a: assert property (access_s ##0 bkp_hit |-> !pslverr)
    else $error("backup word access flagged as error");

endmodule : rtcbd_top

// file: hdl/rtcbd_pkg.sv
// shared constants of the backup-domain real-time clock
package rtcbd_pkg;
  localparam int          RTCBD_NBKP          = 42;
  localparam logic [7:0]  RTCBD_CTRL_OFS      = 8'h00;
  localparam logic [7:0]  RTCBD_STAT_OFS      = 8'h04;
  localparam logic [7:0]  RTCBD_PRESC_OFS     = 8'h08;
  localparam logic [7:0]  RTCBD_DIV_OFS       = 8'h0c;
  localparam logic [7:0]  RTCBD_CNT_OFS       = 8'h10;
  localparam logic [7:0]  RTCBD_ALARM_OFS     = 8'h14;
  localparam logic [7:0]  RTCBD_BKP_OFS       = 8'h40;
  localparam int          RTCBD_SEL_LSB       = 0;
  localparam int          RTCBD_CAL_BIT       = 2;
  localparam int          RTCBD_AIE_BIT       = 3;
  localparam int          RTCBD_SIE_BIT       = 4;
  localparam int          RTCBD_SEC_BIT       = 0;
  localparam int          RTCBD_ALR_BIT       = 1;
  localparam logic [19:0] RTCBD_PRESC_RST     = 20'h07fff;
  localparam logic [31:0] RTCBD_ALARM_RST     = 32'hffffffff;
  localparam logic [31:0] RTCBD_CNT_RST       = 32'h00000000;
  localparam int          RTCBD_FAST_DIV      = 128;
  localparam int          RTCBD_CAL_HALF      = 32;
  typedef enum logic [1:0] {
    RTCBD_SRC_LSE  = 2'b00,
    RTCBD_SRC_LSI  = 2'b01,
    RTCBD_SRC_FAST = 2'b10,
    RTCBD_SRC_OFF  = 2'b11
  } rtcbd_src_t;
endpackage : rtcbd_pkg

// file: sim/rtcbd_clk_src.sv
// low-speed and fast clock sources that feed the rtc clock pins
`timescale 1ns/1ps
module rtcbd_clk_src (
  input  wire logic       pclk,
  input  wire logic [1:0] sel,
  input  wire logic       run,
  output logic            lse,
  output logic            lsi,
  output logic            fast
);
  // one pclk high, one low: launched on pclk, so every level is still sampled;
  // limitation: faster than a real pin allows, traded for a reset prescale in budget
  logic ph;
  initial ph = 1'b0;
  always @(posedge pclk) begin
    if (run || ph) begin
      ph <= !ph;
    end
  end
  // only the chosen source moves, and only inside a burst, so stray edges stay out
  assign lse  = (sel == 2'd0) && ph;
  assign lsi  = (sel == 2'd1) && ph;
  assign fast = (sel == 2'd2) && ph;
endmodule : rtcbd_clk_src

// file: sim/rtcbd_tb_top.sv
// self-checking bench of the backup-domain real-time clock
`timescale 1ns/1ps
`define CHK(a, e) begin \
  n_tests++; \
  if ((a) !== (e)) begin \
    mismatches++; \
    $display("[ERR] %0t mismatch got %h exp %h", $time, a, e); \
  end \
end
module rtcbd_tb_top;
  import rtcbd_pkg::*;
  logic        pclk, presetn, bkp_rst_n, psel, penable, pwrite, pready, pslverr, err, run;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, c0, d;
  logic [31:0] w [RTCBD_NBKP];
  logic        lse, lsi, fast, cal_out, cal_q, alarm_irq, second_irq, alarm_event, standby_wake;
  logic [1:0]  sel;
  int          mismatches, n_tests, cal_edges, alr_events, t;

  rtcbd_top dut_u (.pclk(pclk), .presetn(presetn), .bkp_rst_n(bkp_rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lse_clk_in(lse), .lsi_clk_in(lsi),
    .fast_external_clock_in(fast), .cal_out(cal_out), .alarm_irq(alarm_irq),
    .second_irq(second_irq), .alarm_event(alarm_event), .standby_wake(standby_wake));
  rtcbd_clk_src src_u (.pclk(pclk), .sel(sel), .run(run), .lse(lse), .lsi(lsi), .fast(fast));

  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    cal_q <= cal_out;
    if (cal_q !== cal_out) cal_edges++;
    if (alarm_event === 1'b1) alr_events++;
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude

  // one idle edge after each transfer keeps drivers from double assignment
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 100) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 100) mismatches++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask : rdchk

  task automatic edges(input int n);
    run <= 1'b1;
    repeat (2 * n) @(posedge pclk);
    run <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask : edges

  initial begin
    repeat (90000) @(posedge pclk);
    mismatches++;
    conclude();
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    bkp_rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sel = 2'd0;
    run = 1'b0;
    rd = $urandom(32'hf65a);
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    bkp_rst_n <= 1'b1;
    @(posedge pclk);
    `CHK({cal_out, alarm_irq, second_irq, alarm_event, standby_wake, pready}, 6'b000001)
    rdchk(RTCBD_CTRL_OFS, 32'h0);
    rdchk(RTCBD_PRESC_OFS, {12'h0, RTCBD_PRESC_RST});
    rdchk(RTCBD_ALARM_OFS, RTCBD_ALARM_RST);
    apb(1'b1, RTCBD_DIV_OFS, 32'h0);
    rdchk(RTCBD_DIV_OFS, {12'h0, RTCBD_PRESC_RST});
    apb(1'b0, 8'he8, 32'h0);
    `CHK({err, rd}, 33'h100000000)
    for (int i = 0; i < RTCBD_NBKP; i++) begin
      w[i] = $urandom();
      apb(1'b1, RTCBD_BKP_OFS + 8'(4 * i), w[i]);
    end
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < RTCBD_NBKP; i++) begin
      rdchk(RTCBD_BKP_OFS + 8'(4 * i), {16'h0, w[i][15:0]});
    end
    c0 = $urandom();
    apb(1'b1, RTCBD_CNT_OFS, c0);
    rdchk(RTCBD_CNT_OFS, c0);
    apb(1'b1, RTCBD_CTRL_OFS, 32'h1c);
    apb(1'b1, RTCBD_PRESC_OFS, 32'h3);
    // the first tick waits out the reset divide count: 32768 edges, 2 pclk each
    t = 0;
    run <= 1'b1;
    while (second_irq !== 1'b1 && t < 70000) begin
      @(posedge pclk);
      t++;
    end
    if (t >= 70000) mismatches++;
    run <= 1'b0;
    repeat (8) @(posedge pclk);
    rdchk(RTCBD_CNT_OFS, c0 + 32'd1);
    apb(1'b0, RTCBD_DIV_OFS, 32'h0);
    d = rd;
    apb(1'b1, RTCBD_STAT_OFS, 32'h3);
    apb(1'b1, RTCBD_ALARM_OFS, c0 + 32'd3);
    `CHK({second_irq, alarm_irq}, 2'b00)
    alr_events = 0;
    edges(int'(d) + 1);
    `CHK({second_irq, alarm_irq, standby_wake}, 3'b100)
    rdchk(RTCBD_DIV_OFS, 32'h3);
    edges(4);
    `CHK({alarm_irq, standby_wake, alr_events}, {2'b11, 32'd1})
    rdchk(RTCBD_CNT_OFS, c0 + 32'd3);
    cal_edges = 0;
    edges(128);
    `CHK(cal_edges, 4)
    // source codes 1 and 2 tick once each; code 3 is off and must not tick
    for (int s = 1; s < 4; s++) begin
      apb(1'b1, RTCBD_CTRL_OFS, 32'(s));
      apb(1'b0, RTCBD_CNT_OFS, 32'h0);
      c0 = rd;
      sel <= 2'(s);
      presetn <= 1'b0;
      edges(s == 2 ? 4 * RTCBD_FAST_DIV : 4);
      presetn <= 1'b1;
      @(posedge pclk);
      `CHK(cal_out, 1'b0)
      rdchk(RTCBD_CNT_OFS, c0 + 32'(s < 3));
    end
    conclude();
  end
endmodule : rtcbd_tb_top
